/* File: rtl/vpa_ctl.sv */
// module: channel resource control, status and table load sequencing
// Behaviour
// RULE1: a write of one to load_table_trigger copies the table to the arbiter.
// RULE2: a write of zero to load_table_trigger does nothing.
// RULE3: load_table_trigger always reads back as zero.
// RULE4: the trigger acts only in the upstream port.
// RULE5: the trigger acts only when the selected scheme uses the table.
// RULE6: arbitration_select is three bits; software sets only capable values.
// RULE7: channel_identifier is read-only zero.
// RULE8: channel_enable is read-only one.
// RULE9: table_status sets on any software write to a table entry.
// RULE10: table_status clears only once a requested load has fully latched.
// RULE11: table_status reads zero in a downstream port.
// RULE12: software polls table_status only while the table is in use.
// RULE13: negotiation_pending shows flow control init still in progress.
// RULE14: capability is 0x3 upstream and 0x1 downstream.
// RULE15: an entry naming an invalid port is skipped with no delay.
// RULE16: the arbiter keeps the old table until a load completes.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module vpa_ctl
  import vpa_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic upstream_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic fc_init_busy_i,
  input wire logic [4:0] phase_i,
  output logic [3:0] port_id_o,
  output logic port_id_valid_o,
  output logic [2:0] arb_select_o,
  output logic [7:0] arb_capability_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    vpa_state_t st;
    logic [2:0] sel;
    logic tsts;
    logic neg;
    logic [31:0] rdata;
  } vpa_ctl_st_t;

  vpa_ctl_st_t s_r;
  vpa_ctl_st_t s_nxt;

  logic ctl_wr;
  logic tbl_wr;
  logic ist_wr;
  logic imk_wr;
  logic tbl_used;
  logic load_go;
  logic copy;
  logic [7:0] cap;
  logic [1:0] irq_sts;
  logic [1:0] irq_msk;
  logic [1:0] events;
  logic [31:0] shd_word [VPA_WORDS];
  logic [31:0] ctl_rd;
  logic [31:0] sts_rd;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign cap = upstream_i ? VPA_CAP_UP : VPA_CAP_DN; // RULE14
  assign ctl_wr = wr_i && (addr_i == VPA_CTL_OFF);
  // only the upstream port holds a table
  assign tbl_wr = wr_i && upstream_i && (addr_i[11:4] == VPA_TBL_OFF[11:4]);
  assign ist_wr = wr_i && (addr_i == VPA_IST_OFF);
  assign imk_wr = wr_i && (addr_i == VPA_IMK_OFF);
  // table is used by any capable scheme other than fixed round robin
  assign tbl_used = (s_r.sel != VPA_SEL_RST) && cap[s_r.sel]; // RULE5
  assign load_go = ctl_wr && wdata_i[VPA_LOAD_BIT] // RULE2
                   && upstream_i // RULE4
                   && tbl_used; // RULE5
  assign copy = (s_r.st == VPA_COPY);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (ctl_wr) begin
      // values outside the capability are a software fault; kept as written
      s_nxt.sel = wdata_i[VPA_SEL_HI:VPA_SEL_LO]; // RULE6
    end
    case (s_r.st)
      VPA_IDLE: begin
        if (load_go) begin
          s_nxt.st = VPA_COPY;
        end
      end
      VPA_COPY: begin
        s_nxt.st = VPA_DONE;
      end
      VPA_DONE: begin
        s_nxt.st = VPA_IDLE;
        s_nxt.tsts = 1'b0; // RULE10
      end
      default: begin
        s_nxt.st = VPA_IDLE;
      end
    endcase
    // an entry write in the done cycle keeps the table marked stale; one in the copy cycle is cleared by done
    if (tbl_wr) begin
      s_nxt.tsts = 1'b1; // RULE9
    end
    if (!upstream_i) begin
      s_nxt.tsts = 1'b0; // RULE11
    end
    s_nxt.neg = fc_init_busy_i; // RULE13
    s_nxt.rdata = VPA_ZERO;
    if (rd_i) begin
      case (addr_i)
        VPA_CTL_OFF: s_nxt.rdata = ctl_rd;
        VPA_STS_OFF: s_nxt.rdata = sts_rd;
        VPA_IST_OFF: s_nxt.rdata = {30'h0, irq_sts};
        VPA_IMK_OFF: s_nxt.rdata = {30'h0, irq_msk};
        default: begin
          if (upstream_i && addr_i[11:4] == VPA_TBL_OFF[11:4]) begin
            s_nxt.rdata = shd_word[addr_i[3:2]];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read images
  // ----------------------------------------------------------------
  always_comb begin
    ctl_rd = VPA_ZERO;
    ctl_rd[VPA_LOAD_BIT] = 1'b0; // RULE3
    ctl_rd[VPA_SEL_HI:VPA_SEL_LO] = s_r.sel;
    ctl_rd[VPA_CHID_HI:VPA_CHID_LO] = VPA_CHID_VAL; // RULE7
    ctl_rd[VPA_CHEN_BIT] = VPA_CHEN_VAL; // RULE8
    sts_rd = VPA_ZERO;
    sts_rd[VPA_TSTS_BIT] = s_r.tsts;
    sts_rd[VPA_NEG_BIT] = s_r.neg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_r <= '{st: VPA_IDLE, sel: VPA_SEL_RST, tsts: 1'b0, neg: 1'b0,
               rdata: VPA_ZERO};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // events: load finished, negotiation finished
  // ----------------------------------------------------------------
  assign events[VPA_EV_LOADED] = (s_r.st == VPA_DONE);
  assign events[VPA_EV_NEGDONE] = s_r.neg && !fc_init_busy_i;

  vpa_table u_table (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .wr_i(tbl_wr),
    .wr_idx_i(addr_i[3:2]),
    .wr_data_i(wdata_i),
    .copy_i(copy),
    .phase_i(phase_i),
    .shadow_word_o(shd_word),
    .pid_o(port_id_o),
    .pid_valid_o(port_id_valid_o)
  );

  vpa_irq u_irq (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .event_i(events),
    .sts_we_i(ist_wr),
    .msk_we_i(imk_wr),
    .wdata_i(wdata_i[1:0]),
    .status_o(irq_sts),
    .mask_o(irq_msk),
    .irq_o(irq_o)
  );

  assign rdata_o = s_r.rdata;
  assign arb_select_o = s_r.sel;
  assign arb_capability_o = cap;

endmodule : vpa_ctl

/* File: rtl/vpa_irq.sv */
// module: sticky event status with mask and one level interrupt
`timescale 1ns/1ps
module vpa_irq
  import vpa_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] event_i,
  input wire logic sts_we_i,
  input wire logic msk_we_i,
  input wire logic [1:0] wdata_i,
  output logic [1:0] status_o,
  output logic [1:0] mask_o,
  output logic irq_o
);

  typedef struct packed {
    logic [1:0] sts;
    logic [1:0] msk;
  } vpa_irq_st_t;

  vpa_irq_st_t s_r;
  vpa_irq_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    // set wins over a write-one clear in the same cycle
    if (sts_we_i) begin
      s_nxt.sts = s_r.sts & ~wdata_i;
    end
    s_nxt.sts = s_nxt.sts | event_i;
    if (msk_we_i) begin
      s_nxt.msk = wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_r <= '{sts: VPA_IRQ_RST, msk: VPA_IRQ_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign status_o = s_r.sts;
  assign mask_o = s_r.msk;
  assign irq_o = |(s_r.sts & s_r.msk);

endmodule : vpa_irq

/* File: rtl/vpa_pkg.sv */
// package: register map, field layout and constants of the channel control
package vpa_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] VPA_CTL_OFF = 12'h214;
  localparam logic [11:0] VPA_STS_OFF = 12'h218;
  localparam logic [11:0] VPA_TBL_OFF = 12'h220;
  localparam logic [11:0] VPA_IST_OFF = 12'h300;
  localparam logic [11:0] VPA_IMK_OFF = 12'h304;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int VPA_LOAD_BIT = 16;
  localparam int VPA_SEL_LO = 17;
  localparam int VPA_SEL_HI = 19;
  localparam int VPA_CHID_LO = 24;
  localparam int VPA_CHID_HI = 26;
  localparam int VPA_CHEN_BIT = 31;
  localparam int VPA_TSTS_BIT = 16;
  localparam int VPA_NEG_BIT = 17;

  // ----------------------------------------------------------------
  // table geometry and reset values
  // ----------------------------------------------------------------
  localparam int VPA_PHASES = 32;
  localparam int VPA_WORDS = 4;
  localparam int VPA_PID_W = 4;
  localparam logic [7:0] VPA_CAP_UP = 8'h03;
  localparam logic [7:0] VPA_CAP_DN = 8'h01;
  localparam logic [2:0] VPA_SEL_RST = 3'h0;
  localparam logic [2:0] VPA_CHID_VAL = 3'h0;
  localparam logic VPA_CHEN_VAL = 1'b1;
  localparam logic [31:0] VPA_ZERO = 32'h0;
  localparam logic [1:0] VPA_IRQ_RST = 2'h0;
  localparam int VPA_EV_LOADED = 0;
  localparam int VPA_EV_NEGDONE = 1;
  // a valid port id: 0, 2 or 4
  localparam logic [15:0] VPA_PID_VALID = 16'h0015;

  typedef enum logic [1:0] {
    VPA_IDLE,
    VPA_COPY,
    VPA_DONE
  } vpa_state_t;

endpackage : vpa_pkg

/* File: rtl/vpa_table.sv */
// module: shadow and active arbitration tables with invalid-entry flag
`timescale 1ns/1ps
module vpa_table
  import vpa_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic wr_i,
  input wire logic [1:0] wr_idx_i,
  input wire logic [31:0] wr_data_i,
  input wire logic copy_i,
  input wire logic [4:0] phase_i,
  output logic [31:0] shadow_word_o [VPA_WORDS],
  output logic [3:0] pid_o,
  output logic pid_valid_o
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [VPA_WORDS-1:0][31:0] shd;
    logic [VPA_WORDS-1:0][31:0] act;
  } vpa_tbl_st_t;

  vpa_tbl_st_t s_r;
  vpa_tbl_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (wr_i) begin
      s_nxt.shd[wr_idx_i] = wr_data_i;
    end
    // arbiter keeps the old table until the copy; RULE16
    if (copy_i) begin
      s_nxt.act = s_r.shd; // RULE1
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < VPA_WORDS; g++) begin : g_word
      assign shadow_word_o[g] = s_r.shd[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // phase lookup: an invalid id is flagged so the arbiter skips it
  // ----------------------------------------------------------------
  logic [31:0] act_word;
  assign act_word = s_r.act[phase_i[4:3]];
  assign pid_o = act_word[phase_i[2:0]*VPA_PID_W +: VPA_PID_W];
  assign pid_valid_o = VPA_PID_VALID[pid_o]; // RULE15

endmodule : vpa_table

/* File: tb/tb.sv */
// testbench: self-checking run of the channel control block
`timescale 1ns/1ps
module tb;
  import vpa_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic upstream_i = 1'b1;
  logic [11:0] addr_i = 12'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic fc_init_busy_i = 1'b0;
  logic [4:0] phase_i = 5'h0;
  logic [31:0] rdata_o;
  logic [3:0] port_id_o;
  logic port_id_valid_o;
  logic [2:0] arb_select_o;
  logic [7:0] arb_capability_o;
  logic irq_o;
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] shd [4];
  logic [31:0] act [4];
  vpa_ctl dut (.*);
  always #5 ref_clk_i = ~ref_clk_i;
  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic do_reset(input logic up);
    rstn_i <= 1'b0;
    upstream_i <= up;
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      act[i] = 32'h0;
    end
  endtask : do_reset
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(rdata_o, e);
  endtask : rd
  task automatic irq_is(input logic e);
    @(negedge ref_clk_i);
    chk(32'(irq_o), 32'(e));
  endtask : irq_is
  // walk all phases of the active table against the model
  task automatic chk_tbl();
    logic [3:0] n;
    for (int p = 0; p < 32; p++) begin
      @(posedge ref_clk_i);
      phase_i <= 5'(p);
      @(negedge ref_clk_i);
      n = act[p / 8][(p % 8) * 4 +: 4];
      chk(32'(port_id_o), 32'(n));
      chk(32'(port_id_valid_o), 32'(n inside {4'h0, 4'h2, 4'h4}));
    end
  endtask : chk_tbl
  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    shd[0] = $urandom(84);
    do_reset(1'b1);
    chk(32'(arb_capability_o), 32'(VPA_CAP_UP));
    rd(VPA_CTL_OFF, 32'h8000_0000);
    rd(12'h010, VPA_ZERO);
    for (int i = 0; i < 4; i++) begin
      shd[i] = $urandom;
      wr(VPA_TBL_OFF + 12'(4 * i), shd[i]);
    end
    rd(VPA_STS_OFF, 32'h0001_0000);
    for (int i = 0; i < 4; i++) begin
      rd(VPA_TBL_OFF + 12'(4 * i), shd[i]);
    end
    // old select is 0, so this trigger must not load
    wr(VPA_CTL_OFF, 32'h0003_0000);
    rd(VPA_CTL_OFF, 32'h8002_0000);
    wr(VPA_CTL_OFF, 32'h0002_0000);
    repeat (3) @(posedge ref_clk_i);
    chk_tbl();
    wr(VPA_IMK_OFF, 32'h1);
    irq_is(1'b0);
    wr(VPA_CTL_OFF, 32'h0003_0000);
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 4; i++) begin
      act[i] = shd[i];
    end
    rd(VPA_STS_OFF, VPA_ZERO);
    irq_is(1'b1);
    rd(VPA_IST_OFF, 32'h1);
    chk_tbl();
    wr(VPA_IST_OFF, 32'h1);
    irq_is(1'b0);
    @(posedge ref_clk_i);
    fc_init_busy_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rd(VPA_STS_OFF, 32'h0002_0000);
    @(posedge ref_clk_i);
    fc_init_busy_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rd(VPA_STS_OFF, VPA_ZERO);
    rd(VPA_IST_OFF, 32'h2);
    irq_is(1'b0);
    wr(VPA_IMK_OFF, 32'h3);
    irq_is(1'b1);
    wr(VPA_IST_OFF, 32'h3);
    irq_is(1'b0);
    // downstream port: no table, trigger has no effect
    @(posedge ref_clk_i);
    do_reset(1'b0);
    chk(32'(arb_capability_o), 32'(VPA_CAP_DN));
    wr(VPA_TBL_OFF, shd[0]);
    rd(VPA_TBL_OFF, VPA_ZERO);
    rd(VPA_STS_OFF, VPA_ZERO);
    wr(VPA_CTL_OFF, 32'h0001_0000);
    repeat (3) @(posedge ref_clk_i);
    chk_tbl();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    finish_test();
  end
endmodule : tb

/* File: tb/vpa_ctl_checker.sv */
// checker: port assertions of the channel control block
`timescale 1ns/1ps
module vpa_ctl_checker
  import vpa_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic upstream_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic fc_init_busy_i,
  input wire logic [4:0] phase_i,
  input wire logic [3:0] port_id_o,
  input wire logic port_id_valid_o,
  input wire logic [2:0] arb_select_o,
  input wire logic [7:0] arb_capability_o,
  input wire logic irq_o
);
  // ------------------------------------------
  // assertions
  // ------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic ctl_rd;
  logic sts_rd;
  logic no_load;
  assign ctl_rd = rd_i && addr_i == VPA_CTL_OFF;
  assign sts_rd = rd_i && addr_i == VPA_STS_OFF;
  // select is the old one: the same write cannot arm its own load
  assign no_load = wr_i && (addr_i != VPA_CTL_OFF || !wdata_i[VPA_LOAD_BIT]
    || !upstream_i || arb_select_o != 3'h1);
  property p_cap;
    arb_capability_o == (upstream_i ? VPA_CAP_UP : VPA_CAP_DN);
  endproperty
  a_cap: assert property (p_cap) else $error("bad capability");
  property p_fixed;
    ctl_rd |=> rdata_o[31:20] == 12'h800;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("bad id/enable");
  property p_trig;
    ctl_rd |=> rdata_o[19:16] == {$past(arb_select_o), 1'b0};
  endproperty
  a_trig: assert property (p_trig) else $error("bad ctl read");
  property p_selw;
    wr_i && addr_i == VPA_CTL_OFF |=> arb_select_o == $past(wdata_i[19:17]);
  endproperty
  a_selw: assert property (p_selw) else $error("select not kept");
  property p_dnsts;
    sts_rd && !upstream_i |=> !rdata_o[VPA_TSTS_BIT];
  endproperty
  a_dnsts: assert property (p_dnsts)
    else $error("downstream status");
  property p_neg;
    sts_rd |=> rdata_o[VPA_NEG_BIT] == $past(fc_init_busy_i, 2);
  endproperty
  a_neg: assert property (p_neg) else $error("bad pending bit");
  property p_keep;
    no_load ##1 $stable(phase_i)[*2] |-> $stable(port_id_o);
  endproperty
  a_keep: assert property (p_keep)
    else $error("table moved");
  // quiet cycles around the entry write keep a finishing load out of the way
  property p_tset;
    !wr_i ##1 upstream_i && wr_i && addr_i[11:4] == VPA_TBL_OFF[11:4]
      ##1 !wr_i ##1 sts_rd |=> rdata_o[VPA_TSTS_BIT];
  endproperty
  a_tset: assert property (p_tset) else $error("status not set");
  property p_valid;
    port_id_valid_o == (port_id_o inside {4'h0, 4'h2, 4'h4});
  endproperty
  a_valid: assert property (p_valid) else $error("bad valid flag");
endmodule : vpa_ctl_checker
bind vpa_ctl vpa_ctl_checker u_vpa_chk (.*);
